// ==== rtl/boot_wd_defines.svh ====
// Offsets, field positions, reset values and timing counts of the boot watchdog block.
// Assumes a 10 MHz hclk and word-aligned AHB-Lite register access.
`ifndef BOOT_WD_DEFINES_SVH
`define BOOT_WD_DEFINES_SVH

// Clock rate
`define CLK_MHZ          10
// Register byte offsets
`define ADDR_TB_LO       8'h00
`define ADDR_TB_HI       8'h04
`define ADDR_HID         8'h08
`define ADDR_TSTAT       8'h0c
`define ADDR_TCTRL       8'h10
`define ADDR_STAT        8'h14
// Field positions
`define HID_TBRUN_BIT    0
`define TSTAT_WDEN_BIT   0
`define TSTAT_WDINT_BIT  1
`define TCTRL_WDEN_BIT   8
`define CFG_WDEN_BIT     10
// Reset and boot values
`define TBRUN_RST        1'h1
`define WP_RST           2'h0
`define WPX_RST          4'h0
`define WP_BOOT          2'h1
`define WPX_BOOT         4'h9
`define WD_IDX_BASE      6'h36
`define WD_IDX_MAX       6'h3f
`define MAS0_BASE        32'h1000_0000
`define MMU_LAST_ENTRY   3'h4
`define MMU_TLBWE_STEP   3'h4
// Timing
`define SYNC_SETTLE      3'h4
`define SERIAL_WAIT_US   200
`define SERIAL_WAIT_CYC  (`SERIAL_WAIT_US * `CLK_MHZ)
`define BOOT_INT_US      100
`define BOOT_INT_CYC     (`BOOT_INT_US * `CLK_MHZ)
`define BOOT_EXT_US      150
`define BOOT_EXT_CYC     (`BOOT_EXT_US * `CLK_MHZ)

`endif

// ==== rtl/boot_wd_pkg.sv ====
// Types shared by the boot watchdog block and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package boot_wd_pkg;

	// Boot source taken from the straps
	typedef enum logic [1:0] {
		BOOT_INT     = 2'h0,
		BOOT_EXT     = 2'h1,
		BOOT_EXT_ARB = 2'h2,
		BOOT_SERIAL  = 2'h3
	} boot_mode_type;

	// Boot sequencer, Gray along sync, clear, mmu, branch, run
	typedef enum logic [2:0] {
		ST_SYNC    = 3'h0,
		ST_TBCLR   = 3'h1,
		ST_MMU     = 3'h3,
		ST_BRANCH  = 3'h2,
		ST_RUN     = 3'h6,
		ST_SERWAIT = 3'h7,
		ST_DEBUG   = 3'h5,
		ST_HALT    = 3'h4
	} seq_state_type;

	// Pins sampled from outside the clock domain
	typedef struct packed {
		logic          halt;
		logic          debug;
		boot_mode_type mode;
		logic [15:0]   cfg;
	} strap_type;

	// One write toward the MMU assist registers or the TLB
	typedef struct packed {
		logic        wr;
		logic [1:0]  sel;
		logic [31:0] data;
		logic        tlbwe;
	} mmu_write_type;

	// Boot progress seen by the rest of the chip
	typedef struct packed {
		logic done;
		logic wd_en;
		logic serial_ready;
		logic wd_timeout;
	} boot_status_type;

endpackage : boot_wd_pkg

// ==== rtl/pin_sync3.sv ====
// Three-stage synchroniser for pins from outside the hclk domain.
// Assumes the pins change slowly compared with hclk.
`timescale 1ns/100ps
module pin_sync3 #(
	parameter int W = 20
) (
	// Clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// Pins and their settled copy
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] out;
	} sync_st_type;

	sync_st_type  s_q;
	sync_st_type  s_d;
	logic [W-1:0] agree;

	// A change counts only once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			assign agree[i] = (s_q.s2[i] == s_q.s3[i]) ? s_q.s3[i] : s_q.out[i];
		end
	endgenerate

	// Next stage values; s1 feeds only s2
	always_comb
	begin
		s_d     = s_q;
		s_d.s1  = pin_in;
		s_d.s2  = s_q.s1;
		s_d.s3  = s_q.s2;
		s_d.out = agree;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign pin_out = s_q.out;

endmodule : pin_sync3

// ==== rtl/mmu_entry_rom.sv ====
// Fixed translation entries loaded by the boot sequencer.
// Assumes the caller registers the word it selects.
`timescale 1ns/100ps
`include "boot_wd_defines.svh"
module mmu_entry_rom (
	// Selection
	input  wire logic [2:0]  entry,
	input  wire logic [1:0]  word,
	// Assist register word
	output logic      [31:0] data
);

	// Word 0 selects the entry, words 1 to 3 hold size, page and attributes
	always_comb
	begin
		data = 32'h0000_0000;
		if (word == 2'h0)
			data = `MAS0_BASE | {13'h0, entry, 16'h0};
		else
			unique case ({entry, word})
				5'h01: data = 32'hc000_0500;
				5'h02: data = 32'hfff0_000a;
				5'h03: data = 32'hfff0_003f;
				5'h05: data = 32'hc000_0700;
				5'h06: data = 32'h0000_0000;
				5'h07: data = 32'h0000_003f;
				5'h09: data = 32'hc000_0700;
				5'h0a: data = 32'h2000_0000;
				5'h0b: data = 32'h2000_003f;
				5'h0d: data = 32'hc000_0400;
				5'h0e: data = 32'h4000_0008;
				5'h0f: data = 32'h4000_003f;
				5'h11: data = 32'hc000_0500;
				5'h12: data = 32'hc3f0_0008;
				5'h13: data = 32'hc3f0_003f;
				default: data = 32'h0000_0000;
			endcase
	end

endmodule : mmu_entry_rom

// ==== rtl/boot_watchdog_setup.sv ====
// Boot-time watchdog setup: time base, watchdog, MMU load and boot sequencing.
// Assumes one 10 MHz hclk, straps on pins, serial events from same-clock logic.
//
// Behaviour
// - Normal boot enables watchdog only if config bit
// - Time base cleared before watchdog enable
// - Normal boot timeout three times two^17 clocks
// - Serial boot always enables the watchdog
// - Serial refresh after password, then SRAM writes
// - Zeroing both time base halves refreshes watchdog
// - Cleared run bit stops time base
// - Clearing interrupt status services the watchdog
// - Serial default period select 01, extension 1001
// - Select 00, extension 0000 nearly disables
// - Internal boot finishes under 100 us
// - External boot finishes under 150 us
// - Serial port ready 200 us after reset
// - Debug reset skips the boot program
// - Halt after MMU setup leaves watchdog off
// - TLB write follows all four assist words
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "boot_wd_defines.svh"
module boot_watchdog_setup
	import boot_wd_pkg::*;
(
	// Clock and reset
	input  wire logic            hclk,
	input  wire logic            hresetn,
	// AHB-Lite slave
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic                 hreadyout,
	output logic                 hresp,
	output logic      [31:0]     hrdata,
	// Straps and debugger pins
	input  wire strap_type       strap_pins,
	// Serial download events
	input  wire logic            password_ok,
	input  wire logic            sram_wr,
	// Results
	output mmu_write_type        mmu_out,
	output boot_status_type      status,
	output logic      [63:0]     time_base
);

	typedef struct packed {
		seq_state_type st;
		logic [2:0]    settle;
		logic [2:0]    entry;
		logic [2:0]    step;
		logic [10:0]   wait_cnt;
		logic [10:0]   boot_cyc;
		boot_mode_type mode;
		logic          cfg_wden;
		logic [63:0]   tb;
		logic          tb_run;
		logic          wd_int;
		logic          wd_en;
		logic [1:0]    wp;
		logic [3:0]    wp_ext;
		logic          pw_ok;
		logic          done;
		logic          serial_ready;
		logic          timeout;
		mmu_write_type mmu;
		logic          ph_valid;
		logic          ph_write;
		logic [7:0]    ph_addr;
		logic [31:0]   rdata;
	} bw_st_type;

	localparam bw_st_type RST = '{
		st: ST_SYNC, mode: BOOT_INT, tb_run: `TBRUN_RST,
		wp: `WP_RST, wp_ext: `WPX_RST, default: '0};

	bw_st_type   s_q;
	bw_st_type   s_d;
	strap_type   straps;
	logic [31:0] rom_data;
	logic [63:0] tb_inc;
	logic [5:0]  wd_idx;
	logic        tick;
	logic        wr_phase;
	logic        addr_phase;

	// Pins cross into hclk through three stages
	pin_sync3 #(
		.W       ($bits(strap_type))
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin_in  (strap_pins),
		.pin_out (straps)
	);

	// Translation words for the current entry and step
	mmu_entry_rom u_rom (
		.entry (s_q.entry),
		.word  (s_q.step[1:0]),
		.data  (rom_data)
	);

	// Period select to time base bit; 00/0000 picks the top bit
	function automatic logic [5:0] wd_idx_f(input logic [1:0] wp, input logic [3:0] wp_ext);
		logic [5:0] sel;
		sel = {wp_ext, wp};
		if (sel == 6'h00)
			return `WD_IDX_MAX;
		else if (sel > `WD_IDX_BASE)
			return 6'h00;
		else
			return 6'(`WD_IDX_BASE - sel);
	endfunction : wd_idx_f

	// Watchdog event on a rising edge of the selected time base bit
	assign tb_inc     = s_q.tb + 64'h1;
	assign wd_idx     = wd_idx_f(s_q.wp, s_q.wp_ext);
	assign tick       = s_q.tb_run && s_q.wd_en && tb_inc[wd_idx] && !s_q.tb[wd_idx];
	assign wr_phase   = s_q.ph_valid && s_q.ph_write;
	assign addr_phase = hsel && htrans[1] && hready;

	// Whole next state; watchdog bite comes last so it wins
	always_comb
	begin
		s_d           = s_q;
		s_d.mmu.wr    = 1'b0;
		s_d.mmu.tlbwe = 1'b0;
		s_d.timeout   = 1'b0;
		if (s_q.tb_run)
			s_d.tb = tb_inc;
		if (!s_q.done && s_q.boot_cyc != 11'h7ff)
			s_d.boot_cyc = s_q.boot_cyc + 11'h1;

		// Boot sequencer
		unique case (s_q.st)
			ST_SYNC:
			begin
				if (s_q.settle != `SYNC_SETTLE)
					s_d.settle = s_q.settle + 3'h1;
				else
				begin
					s_d.mode     = straps.mode;
					s_d.cfg_wden = straps.cfg[`CFG_WDEN_BIT];
					s_d.st       = straps.debug ? ST_DEBUG : ST_TBCLR;
				end
			end
			ST_TBCLR:
			begin
				s_d.tb     = 64'h0;
				s_d.wd_int = 1'b0;
				s_d.entry  = 3'h0;
				s_d.step   = 3'h0;
				s_d.st     = ST_MMU;
			end
			ST_MMU:
			begin
				if (s_q.step == `MMU_TLBWE_STEP)
				begin
					s_d.mmu.tlbwe = 1'b1;
					s_d.step      = 3'h0;
					if (s_q.entry == `MMU_LAST_ENTRY)
						s_d.st = straps.halt ? ST_HALT : ST_BRANCH;
					else
						s_d.entry = s_q.entry + 3'h1;
				end
				else
				begin
					s_d.mmu.wr   = 1'b1;
					s_d.mmu.sel  = s_q.step[1:0];
					s_d.mmu.data = rom_data;
					s_d.step     = s_q.step + 3'h1;
				end
			end
			ST_BRANCH:
			begin
				s_d.wp     = `WP_BOOT;
				s_d.wp_ext = `WPX_BOOT;
				if (s_q.mode == BOOT_SERIAL)
				begin
					s_d.wd_en    = 1'b1;
					s_d.wait_cnt = 11'h0;
					s_d.st       = ST_SERWAIT;
				end
				else
				begin
					s_d.wd_en = s_q.cfg_wden;
					s_d.done  = 1'b1;
					s_d.st    = ST_RUN;
				end
			end
			ST_SERWAIT:
			begin
				if (s_q.wait_cnt == 11'(`SERIAL_WAIT_CYC - 1))
				begin
					s_d.serial_ready = 1'b1;
					s_d.done         = 1'b1;
					s_d.st           = ST_RUN;
				end
				else
					s_d.wait_cnt = s_q.wait_cnt + 11'h1;
			end
			ST_RUN, ST_DEBUG, ST_HALT:
				s_d.st = s_q.st;
		endcase

		// Serial refresh only after an accepted password
		if (s_q.st == ST_RUN && s_q.mode == BOOT_SERIAL)
		begin
			if (password_ok)
			begin
				s_d.pw_ok = 1'b1;
				s_d.tb    = 64'h0;
			end
			else if (sram_wr && s_q.pw_ok)
				s_d.tb = 64'h0;
		end

		// Data phase of a write; every access is zero wait
		if (wr_phase)
			unique case (s_q.ph_addr)
				`ADDR_TB_LO: s_d.tb[31:0]  = hwdata;
				`ADDR_TB_HI: s_d.tb[63:32] = hwdata;
				`ADDR_HID:   s_d.tb_run    = hwdata[`HID_TBRUN_BIT];
				`ADDR_TSTAT:
				begin
					if (hwdata[`TSTAT_WDINT_BIT])
						s_d.wd_int = 1'b0;
				end
				`ADDR_TCTRL:
				begin
					s_d.wp     = hwdata[1:0];
					s_d.wp_ext = hwdata[5:2];
					s_d.wd_en  = s_q.wd_en | hwdata[`TCTRL_WDEN_BIT];
				end
				default: s_d.tb_run = s_d.tb_run;
			endcase

		// Address phase; read data is ready for the data phase
		s_d.ph_valid = addr_phase;
		s_d.ph_write = hwrite;
		s_d.ph_addr  = haddr[7:0];
		if (addr_phase && !hwrite)
			unique case (haddr[7:0])
				`ADDR_TB_LO: s_d.rdata = s_q.tb[31:0];
				`ADDR_TB_HI: s_d.rdata = s_q.tb[63:32];
				`ADDR_HID:   s_d.rdata = {31'h0, s_q.tb_run};
				`ADDR_TSTAT: s_d.rdata = {30'h0, s_q.wd_int, s_q.wd_en};
				`ADDR_TCTRL: s_d.rdata = {23'h0, s_q.wd_en, 2'h0, s_q.wp_ext, s_q.wp};
				`ADDR_STAT:  s_d.rdata = {24'h0, s_q.st, s_q.mode, s_q.pw_ok, s_q.serial_ready, s_q.done};
				default:     s_d.rdata = 32'h0;
			endcase

		// First event raises status, second one with status still set bites
		if (tick)
		begin
			if (s_q.wd_int)
			begin
				s_d         = RST;
				s_d.timeout = 1'b1;
			end
			else
				s_d.wd_int = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s_q <= RST;
		else
			s_q <= s_d;
	end

	// Outputs; the slave never stalls and never errors
	assign hreadyout           = 1'b1;
	assign hresp               = 1'b0;
	assign hrdata              = s_q.rdata;
	assign mmu_out             = s_q.mmu;
	assign status              = '{
		done: s_q.done, wd_en: s_q.wd_en,
		serial_ready: s_q.serial_ready,
		wd_timeout: s_q.timeout};
	assign time_base           = s_q.tb;

	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_CFG_GATE: assert property (
		(s_q.st == ST_BRANCH && s_q.mode != BOOT_SERIAL && !tick) |=> (s_q.wd_en == $past(s_q.cfg_wden)))
		else $error("watchdog enable does not follow config bit");
	AST_TB_ZERO: assert property (
		(s_q.st == ST_TBCLR) |=> (s_q.tb == 64'h0 && s_q.st == ST_MMU))
		else $error("time base not cleared before enable");
	AST_BOOT_PERIOD: assert property (
		(s_q.st == ST_BRANCH && s_q.mode != BOOT_SERIAL) |=> (wd_idx == 6'h11))
		else $error("normal boot period wrong");
	AST_SERIAL_ON: assert property (
		(s_q.st == ST_BRANCH && s_q.mode == BOOT_SERIAL) |=> (s_q.wd_en && s_q.st == ST_SERWAIT))
		else $error("serial boot left watchdog off");
	AST_PW_REFRESH: assert property (
		(s_q.st == ST_RUN && s_q.mode == BOOT_SERIAL && (password_ok || (sram_wr && s_q.pw_ok))
		 && !wr_phase) |=> (s_q.tb == 64'h0))
		else $error("serial refresh missing");
	AST_TB_WRITE: assert property (
		(wr_phase && s_q.ph_addr == `ADDR_TB_LO && hwdata == 32'h0) |=> (s_q.tb[31:0] == 32'h0))
		else $error("time base write ignored");
	AST_TB_HOLD: assert property (
		(!s_q.tb_run && !s_q.ph_valid && s_q.st != ST_TBCLR && !password_ok && !sram_wr)
		|=> $stable(s_q.tb))
		else $error("time base moved while stopped");
	AST_EVENT_FIRST: assert property (
		(tick && !s_q.wd_int) |=> (s_q.wd_int && !s_q.timeout))
		else $error("first watchdog event bit");
	AST_SERIAL_PERIOD: assert property (
		(s_q.st == ST_BRANCH && s_q.mode == BOOT_SERIAL) |=> (s_q.wp == 2'h1 && s_q.wp_ext == 4'h9))
		else $error("serial default period wrong");
	AST_LONG_PERIOD: assert property (
		(wr_phase && s_q.ph_addr == `ADDR_TCTRL && hwdata[5:0] == 6'h0 && !tick) |=> (wd_idx == 6'h3f))
		else $error("zero period select not longest");
	AST_INT_BUDGET: assert property (
		($rose(s_q.done) && s_q.mode == BOOT_INT) |-> (s_q.boot_cyc < 11'(`BOOT_INT_CYC)))
		else $error("internal boot too slow");
	AST_EXT_BUDGET: assert property (
		($rose(s_q.done) && s_q.mode inside {BOOT_EXT, BOOT_EXT_ARB}) |-> (s_q.boot_cyc < 11'(`BOOT_EXT_CYC)))
		else $error("external boot too slow");
	AST_SERIAL_WAIT: assert property (
		$rose(s_q.serial_ready) |-> ($past(s_q.wait_cnt) == 11'(`SERIAL_WAIT_CYC - 1)))
		else $error("serial wait length wrong");
	AST_DEBUG_QUIET: assert property (
		(s_q.st == ST_DEBUG) |-> (!s_q.wd_en && !s_q.mmu.wr && !s_q.mmu.tlbwe))
		else $error("boot program ran in debug");
	AST_HALT_OFF: assert property (
		(s_q.st == ST_HALT) |-> !s_q.wd_en)
		else $error("watchdog on while halted");
	AST_TLB_AFTER_MAS: assert property (
		s_q.mmu.tlbwe |-> ($past(s_q.mmu.wr) && $past(s_q.mmu.sel) == 2'h3))
		else $error("TLB write before assist words");
	AST_BITE: assert property (
		(tick && s_q.wd_int) |=> s_q.timeout ##1 (s_q.st == ST_SYNC && !s_q.wd_en))
		else $error("expiry did not restart boot");

	COV_SERIAL: cover property ($rose(s_q.serial_ready));
	COV_INT_WD: cover property ($rose(s_q.done) && s_q.wd_en && s_q.mode == BOOT_INT);
	COV_BITE: cover property (s_q.timeout);
	COV_HALT: cover property (s_q.st == ST_HALT);

endmodule : boot_watchdog_setup

// ==== bench/boot_host_model.sv ====
// Far side: debugger straps, serial download events, monitor of MMU writes.
// Assumes the same hclk and hresetn as the block; events are one-cycle pulses.
`timescale 1ns/100ps
module boot_host_model
	import boot_wd_pkg::*;
(
	// Clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// Pins and events toward the block
	output strap_type          strap_pins,
	output logic               password_ok,
	output logic               sram_wr,
	// MMU writes from the block
	input  wire mmu_write_type mmu_out
);
	int unsigned wr_cnt;
	int unsigned we_cnt;
	int unsigned bad_cnt;
	logic [2:0]  word_q;
	initial
	begin
		strap_pins  = '0;
		password_ok = 1'b0;
		sram_wr     = 1'b0;
	end
	// Straps are set while reset is held; a debug strap means the debugger sets up the MMU itself
	task automatic set_pins(input logic dbg, input logic hlt, input boot_mode_type m, input logic [15:0] c);
		strap_pins <= '{halt: hlt, debug: dbg, mode: m, cfg: c};
	endtask : set_pins
	// A set pw gives one password_ok pulse, a clear pw gives one sram_wr pulse instead
	task automatic pulse(input logic pw);
		@(posedge hclk);
		password_ok <= pw;
		sram_wr     <= !pw;
		@(posedge hclk);
		password_ok <= 1'b0;
		sram_wr     <= 1'b0;
	endtask : pulse
	// Four assist words in order, then one TLB write; entry index wraps after a bite restart
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_cnt  <= 0;
			we_cnt  <= 0;
			bad_cnt <= 0;
			word_q  <= 3'h0;
		end
		else if (mmu_out.wr)
		begin
			wr_cnt <= wr_cnt + 1;
			word_q <= word_q + 3'h1;
			if ({1'b0, mmu_out.sel} != word_q || (word_q == 3'h0
				&& mmu_out.data != (32'h1000_0000 | (32'(we_cnt % 5) << 16))))
				bad_cnt <= bad_cnt + 1;
		end
		else if (mmu_out.tlbwe)
		begin
			we_cnt <= we_cnt + 1;
			word_q <= 3'h0;
			if (word_q != 3'h4)
				bad_cnt <= bad_cnt + 1;
		end
	end
endmodule : boot_host_model

// ==== bench/tb_top.sv ====
// Self-checking bench: boot modes, watchdog service, serial refresh, debug and halt.
// Assumes zero-wait AHB-Lite slave and no bite before each scenario resets the block.
`timescale 1ns/100ps
`include "boot_wd_defines.svh"
module tb_top
	import boot_wd_pkg::*;
;
	localparam logic [7:0] OFF_LO = 8'h00, OFF_HI = 8'h04, OFF_RUN = 8'h08, OFF_ST = 8'h0c, OFF_CTL = 8'h10;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, password_ok, sram_wr;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [63:0] time_base, t1;
	strap_type strap_pins;
	mmu_write_type mmu_out;
	boot_status_type status;
	int mismatches, checks_done, cyc;
	logic bit_v;

	boot_watchdog_setup uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .strap_pins(strap_pins), .password_ok(password_ok), .sram_wr(sram_wr),
		.mmu_out(mmu_out), .status(status), .time_base(time_base));
	boot_host_model host (.hclk(hclk), .hresetn(hresetn), .strap_pins(strap_pins), .password_ok(password_ok),
		.sram_wr(sram_wr), .mmu_out(mmu_out));

	// 10 MHz clock
	initial
	begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	// Address phase held until hready, then data phase held until hready
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : ahb
	// Reset with given straps, then count cycles until done or the limit
	task automatic boot(input logic dbg, hlt, input boot_mode_type m, input logic [15:0] c, input int lim);
		@(posedge hclk);
		hresetn <= 1'b0;
		host.set_pins(dbg, hlt, m, c);
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		for (cyc = 0; cyc < lim && status.done !== 1'b1; cyc++)
			@(posedge hclk);
	endtask : boot
	// Puts time base just below a rising edge of bit 17, reports any bite
	task automatic wd_event(output logic bite);
		ahb(1'b1, OFF_LO, 32'h0001_fff8, rd);
		bite = 1'b0;
		repeat (30)
		begin
			@(posedge hclk);
			bite |= status.wd_timeout;
		end
	endtask : wd_event
	task automatic t_modes();
		for (int m = 0; m < 3; m++)
		begin
			boot(1'b0, 1'b0, boot_mode_type'(m), m[0] ? 16'h0400 : 16'h0000, 3000);
			check(status.wd_en, m[0]);
			check(cyc < (m == 0 ? `BOOT_INT_CYC : `BOOT_EXT_CYC), 1'b1);
			check(time_base < 64, 1'b1);
		end
	endtask : t_modes
	task automatic t_service();
		boot(1'b0, 1'b0, BOOT_INT, 16'h0400, 3000);
		wd_event(bit_v);
		check(bit_v, 1'b0);
		ahb(1'b0, OFF_ST, 32'h0, rd);
		check(rd[1], 1'b1);
		ahb(1'b1, OFF_ST, 32'h2, rd);
		ahb(1'b0, OFF_ST, 32'h0, rd);
		check(rd[1], 1'b0);
		wd_event(bit_v);
		check(bit_v, 1'b0);
		wd_event(bit_v);
		check(bit_v, 1'b1);
		check(status.done, 1'b0);
		for (cyc = 0; cyc < 1000 && status.done !== 1'b1; cyc++)
			@(posedge hclk);
		check(status.done, 1'b1);
	endtask : t_service
	task automatic t_stop();
		boot(1'b0, 1'b0, BOOT_INT, 16'h0400, 3000);
		ahb(1'b1, OFF_RUN, 32'h0, rd);
		@(posedge hclk);
		t1 = time_base;
		repeat (10) @(posedge hclk);
		check(time_base, t1);
		wd_event(bit_v);
		ahb(1'b0, OFF_ST, 32'h0, rd);
		check({bit_v, rd[1]}, 2'b00);
		ahb(1'b1, OFF_RUN, 32'h1, rd);
		ahb(1'b1, OFF_HI, 32'h1, rd);
		ahb(1'b1, OFF_HI, 32'h0, rd);
		ahb(1'b1, OFF_LO, 32'h0, rd);
		@(posedge hclk);
		check(time_base < 8, 1'b1);
		ahb(1'b1, 8'h18, 32'hffff_ffff, rd);
		ahb(1'b0, 8'h18, 32'h0, rd);
		check({hresp, rd}, 33'h0);
	endtask : t_stop
	task automatic t_serial();
		boot(1'b0, 1'b0, BOOT_SERIAL, 16'h0000, 3000);
		check(status.serial_ready, 1'b1);
		check(cyc >= `SERIAL_WAIT_CYC && cyc < `SERIAL_WAIT_CYC + 100, 1'b1);
		check(status.wd_en, 1'b1);
		ahb(1'b0, OFF_CTL, 32'h0, rd);
		check(rd[5:0], {`WPX_BOOT, `WP_BOOT});
		host.pulse(1'b0);
		@(posedge hclk);
		check(time_base > 8, 1'b1);
		host.pulse(1'b1);
		@(posedge hclk);
		check(time_base < 4, 1'b1);
		repeat (20) @(posedge hclk);
		host.pulse(1'b0);
		@(posedge hclk);
		check(time_base < 4, 1'b1);
		ahb(1'b1, OFF_CTL, 32'h0000_0100, rd);
		wd_event(bit_v);
		ahb(1'b0, OFF_ST, 32'h0, rd);
		check({bit_v, rd[1]}, 2'b00);
	endtask : t_serial
	task automatic t_debug_halt();
		boot(1'b1, 1'b0, BOOT_INT, 16'h0400, 100);
		check({status.done, status.wd_en, 32'(host.wr_cnt)}, 34'h0);
		boot(1'b0, 1'b1, BOOT_INT, 16'h0400, 100);
		check({status.done, status.wd_en}, 2'b00);
		check(host.wr_cnt, 64'd20);
		check({host.we_cnt, host.bad_cnt}, {32'd5, 32'd0});
	endtask : t_debug_halt
	// Main sequence
	initial
	begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		mismatches = 0;
		checks_done = 0;
		t_modes();
		t_service();
		t_stop();
		t_serial();
		t_debug_halt();
		report_and_stop();
	end
	// Watchdog of the run at 60000 cycles, well above the expected 3000 cycles
	initial
	begin
		#6000000;
		mismatches++;
		report_and_stop();
	end
endmodule : tb_top
